/* File: logic/sckc_clock_ctrl.sv */
// Purpose: Trim, protected system clock divider, PLL control/status and core control register
// Assumes: Fuse and factory trim inputs are stable across reset release
// Notes:   Divided clock is given as a one-cycle enable pulse on the master clock
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/100ps
`include "sckc_regs.svh"
module sckc_clock_ctrl
(
  input  wire logic                   CLOCK,
  input  wire logic                   RST,
  input  wire sckc_pkg::sckc_apb_req_s APB_REQ,
  output      sckc_pkg::sckc_apb_rsp_s APB_RSP,
  input  wire logic [7:0]             FACTORY_TRIM,
  input  wire logic                   DIV8_FUSE,
  input  wire logic                   CLOCK_SELECT_FUSE_BIT2_FUSE,
  input  wire logic                   PLL_IS_SYSCLK,
  input  wire logic                   PLL_LOCKED,
  input  wire logic                   RC_RUNNING,
  output      logic [7:0]             TRIM_OUT,
  output      logic                   SYS_CLK_EN,
  output      logic                   PLL_ON,
  output      logic [3:0]             PLL_MULT_CODE,
  output      logic                   RC_START,
  output      logic                   PSC_PLL_EN,
  output      logic                   RC_FREQ_1MHZ
);
  import sckc_pkg::*;

  sckc_state_s s;
  sckc_state_s next_s;

  // Divider period mask for code 0..8
  function automatic logic [7:0] div_mask(input logic [3:0] code);
    div_mask = 8'((9'h001 << code) - 9'h001);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic       wr;
    logic [7:0] wd;
    logic       pll_en_rd;
    next_s = s;
    wr = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite;
    wd = APB_REQ.pwdata[7:0];
    pll_en_rd = s.pll_enable | PLL_IS_SYSCLK;
    // Straps are caught on the first clock after reset release
    if (!s.loaded)
    begin
      next_s.loaded  = 1'b1;
      next_s.trim    = FACTORY_TRIM;
      next_s.div_sel = DIV8_FUSE ? `SCKC_DIV8_SEL : 4'h0;
      next_s.div_eff = next_s.div_sel;
      next_s.core[`SCKC_CORE_FUSE_BIT] = CLOCK_SELECT_FUSE_BIT2_FUSE;
    end
    // Window countdown starts the cycle after the enabling write
    if (s.ce)
    begin
      next_s.win = s.win - 3'h1;
      if (s.win == 3'h1)
        next_s.ce = 1'b0;
    end
    next_s.rsp = '0;
    if (APB_REQ.psel & APB_REQ.penable & ~s.rsp.pready)
    begin
      next_s.rsp.pready = 1'b1;
      unique case (APB_REQ.paddr)
        `SCKC_ADDR_TRIM:
        begin
          if (wr)
            next_s.trim = wd;
          next_s.rsp.prdata = {24'h0, s.trim};
        end
        `SCKC_ADDR_DIV:
        begin
          if (wr && wd == 8'h80 && !s.ce)
          begin
            next_s.ce  = 1'b1;
            next_s.win = `SCKC_WINDOW;
          end
          else if (wr && !wd[`SCKC_DIV_CE_BIT] && s.ce)
          begin
            next_s.ce      = 1'b0;
            next_s.div_sel = wd[3:0];
            if (wd[3:0] <= `SCKC_DIV_SEL_MAX)
              next_s.div_eff = wd[3:0];
          end
          // A repeat enable write falls through unchanged
          next_s.rsp.prdata = {24'h0, s.ce, 3'h0, s.div_sel};
        end
        `SCKC_ADDR_PLL:
        begin
          if (wr)
          begin
            next_s.pll_factor = wd[5:2];
            if (wd[5:2] >= `SCKC_PLL_FACTOR_MIN && wd[5:2] <= `SCKC_PLL_FACTOR_MAX)
              next_s.pll_factor_eff = wd[5:2];
            next_s.pll_enable = wd[1];
          end
          next_s.rsp.prdata = {24'h0, 2'h0, s.pll_factor, pll_en_rd, PLL_LOCKED};
        end
        `SCKC_ADDR_CORE:
        begin
          if (wr)
            next_s.core = wd[4:0];
          next_s.rsp.prdata = {24'h0, 3'h0, s.core};
        end
        default:
          next_s.rsp.pslverr = 1'b1;
      endcase
    end
    // RC select is forced low while the RC oscillator stands and the PLL is not enabled
    if (!RC_RUNNING && !s.pll_enable)
      next_s.core[`SCKC_CORE_RCSEL_BIT] = 1'b0;
    // Divider: new code takes effect the cycle after the write, mid-period, so a short pulse period can occur
    if ((s.cnt & div_mask(s.div_eff)) == div_mask(s.div_eff))
    begin
      next_s.cnt    = 8'h00;
      next_s.clk_en = 1'b1;
    end
    else
    begin
      next_s.cnt    = s.cnt + 8'h01;
      next_s.clk_en = 1'b0;
    end
    next_s.psc_pll_en = (s.pll_enable | PLL_IS_SYSCLK) & PLL_LOCKED;
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      s          <= '0;
      s.pll_factor     <= `SCKC_PLL_FACTOR_RST;
      s.pll_factor_eff <= `SCKC_PLL_FACTOR_RST;
    end
    else
      s <= next_s;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state flops
  always_comb
  begin
    APB_RSP       = s.rsp;
    TRIM_OUT      = s.trim;
    SYS_CLK_EN    = s.clk_en;
    PLL_ON        = s.pll_enable;
    PLL_MULT_CODE = s.pll_factor_eff;
    RC_START      = s.pll_enable;
    PSC_PLL_EN    = s.psc_pll_en;
    RC_FREQ_1MHZ  = s.core[`SCKC_CORE_RCSEL_BIT];
  end
endmodule // sckc_clock_ctrl

/* File: pkg/sckc_regs.svh */
// Purpose: Register offsets, field positions, reset values and timing counts of the clock control block
// Assumes: APB byte addresses; printed offsets that are not multiples of four are indexes times four
// Notes:   Definitions only
`ifndef SCKC_REGS_SVH
`define SCKC_REGS_SVH
`define SCKC_PLL_IDX      8'h29
`define SCKC_ADDR_PLL     12'h0a4
`define SCKC_ADDR_TRIM    12'h000
`define SCKC_ADDR_DIV     12'h004
`define SCKC_ADDR_CORE    12'h008
`define SCKC_DIV_CE_BIT   7
`define SCKC_DIV_SEL_MAX  4'h8
`define SCKC_DIV8_SEL     4'h3
`define SCKC_WINDOW       3'h4
`define SCKC_PLL_FACTOR_MIN     4'h2
`define SCKC_PLL_FACTOR_MAX     4'h6
`define SCKC_PLL_FACTOR_RST     4'h4
`define SCKC_CORE_FUSE_BIT 3
`define SCKC_CORE_RCSEL_BIT 2
`define SCKC_CORE_MASK    8'h1f
`endif

/* File: pkg/sckc_pkg.sv */
// Purpose: Types shared by the clock control block
// Assumes: Constants live in sckc_regs.svh
// Notes:   None
package sckc_pkg;
  typedef struct packed
  {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sckc_apb_req_s;

  typedef struct packed
  {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } sckc_apb_rsp_s;

  typedef struct packed
  {
    logic [7:0] trim;
    logic       ce;
    logic [2:0] win;
    logic [3:0] div_sel;
    logic [3:0] div_eff;
    logic [3:0] pll_factor;
    logic [3:0] pll_factor_eff;
    logic       pll_enable;
    logic [4:0] core;
    logic [7:0] cnt;
    logic       clk_en;
    logic       psc_pll_en;
    logic       loaded;
    sckc_apb_rsp_s rsp;
  } sckc_state_s;
endpackage

/* File: bench/sckc_clock_ctrl_monitor.sv */
// Purpose: Port-level checks of the clock control block
// Assumes: One clock, asynchronous active-high RST
// Notes:   Bound into every instance of the block
`timescale 1ns/100ps
`include "sckc_regs.svh"
module sckc_monitor
(
  input wire logic                    CLOCK,
  input wire logic                    RST,
  input wire sckc_pkg::sckc_apb_req_s APB_REQ,
  input wire sckc_pkg::sckc_apb_rsp_s APB_RSP,
  input wire logic [7:0]              FACTORY_TRIM,
  input wire logic                    PLL_IS_SYSCLK,
  input wire logic                    PLL_LOCKED,
  input wire logic                    RC_RUNNING,
  input wire logic [7:0]              TRIM_OUT,
  input wire logic                    PLL_ON,
  input wire logic [3:0]              PLL_MULT_CODE,
  input wire logic                    RC_START,
  input wire logic                    PSC_PLL_EN,
  input wire logic                    RC_FREQ_1MHZ
);
  import sckc_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////////////////////
  // Trim load waits one edge, so the check lands on the second edge
  trim_reset_a: assert property ($fell(RST) |=> TRIM_OUT == FACTORY_TRIM)
    else $error("trim not loaded");
  rc_start_a: assert property (RC_START == PLL_ON) else $error("rc start off");
  lock_gate_a: assert property (PSC_PLL_EN |-> $past(PLL_LOCKED)) else $error("pll clock unlocked");
  pll_code_a: assert property (PLL_MULT_CODE inside {[4'h2:4'h6]}) else $error("bad factor");
  div_res_a: assert property (APB_RSP.pready && APB_REQ.paddr == `SCKC_ADDR_DIV |-> APB_RSP.prdata[6:4] == 3'h0)
    else $error("reserved bits set");
  rcsel_clear_a: assert property (!RC_RUNNING && !PLL_ON |=> !RC_FREQ_1MHZ) else $error("rc select kept");
  // The forced one shows in the read-back, not on PLL_ON, which follows the stored bit
  pll_force_a: assert property (APB_RSP.pready && APB_REQ.paddr == `SCKC_ADDR_PLL && $past(PLL_IS_SYSCLK)
    |-> APB_RSP.prdata[1]) else $error("pll enable low");
  pready_pulse_a: assert property (APB_RSP.pready |=> !APB_RSP.pready) else $error("pready stuck");
  refuse_zero_a: assert property (APB_RSP.pslverr |-> APB_RSP.prdata == 32'h0) else $error("refused data");
endmodule // sckc_monitor
bind sckc_clock_ctrl sckc_monitor i_sckc_monitor (.CLOCK, .RST, .APB_REQ, .APB_RSP, .FACTORY_TRIM, .PLL_IS_SYSCLK,
  .PLL_LOCKED, .RC_RUNNING, .TRIM_OUT, .PLL_ON, .PLL_MULT_CODE, .RC_START, .PSC_PLL_EN, .RC_FREQ_1MHZ);

/* File: bench/sckc_clock_ctrl_tb.sv */
// Purpose: Self-checking bench of the clock control block
// Assumes: APB answer arrives within 20 cycles
// Notes:   Divider period measured on the clock enable pulse
`timescale 1ns/100ps
`include "sckc_regs.svh"
`define CHK(g,e) begin total_checks++; if ((g)!==(e)) begin n_errors++; $display("CHECK FAILED t=%0t %h %h",$time,g,e); end end
module sckc_clock_ctrl_tb;
  import sckc_pkg::*;
  logic          clk = 0, rst = 1, err, div8, cks2, sysclk = 0, lock = 0, rcrun = 1, clk_en, pll_on, psc_en, rc1;
  logic [7:0]    trim_in, trim_o;
  logic [3:0]    mult;
  logic [31:0]   rd;
  sckc_apb_req_s q = '0;
  sckc_apb_rsp_s s;
  int            n_errors = 0, total_checks = 0, m_eff, p;
  sckc_clock_ctrl i_sckc_clock_ctrl (.CLOCK(clk), .RST(rst), .APB_REQ(q), .APB_RSP(s), .FACTORY_TRIM(trim_in),
    .DIV8_FUSE(div8), .CLOCK_SELECT_FUSE_BIT2_FUSE(cks2), .PLL_IS_SYSCLK(sysclk), .PLL_LOCKED(lock), .RC_RUNNING(rcrun),
    .TRIM_OUT(trim_o), .SYS_CLK_EN(clk_en), .PLL_ON(pll_on), .PLL_MULT_CODE(mult), .RC_START(),
    .PSC_PLL_EN(psc_en), .RC_FREQ_1MHZ(rc1));
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Chained calls keep psel up so the divider window is hit in time
  task automatic rw(input logic w, input logic [11:0] a, input logic [7:0] d, input logic k);
    int i;
    q.psel <= 1; q.penable <= 0; q.pwrite <= w; q.paddr <= a; q.pwdata <= {24'h0, d};
    @(posedge clk) q.penable <= 1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk);
      if (s.pready === 1'b1) break;
    end
    if (i == 20) begin n_errors++; test_done; end
    rd = s.prdata; err = s.pslverr;
    if (!k) begin q.psel <= 0; q.penable <= 0; @(posedge clk); end
  endtask
  // Cycles between two enable pulses
  task automatic per(output int n);
    int i;
    for (i = 0; i < 600 && clk_en !== 1'b1; i++) @(posedge clk);
    @(posedge clk) n = 1;
    for (i = 0; i < 600 && clk_en !== 1'b1; i++) begin @(posedge clk); n++; end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h3b7c30bc));
    trim_in = $urandom; div8 = $urandom; cks2 = $urandom;
    repeat (6) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    rw(0, `SCKC_ADDR_TRIM, 0, 0); `CHK(rd, {24'h0, trim_in})
    rw(0, `SCKC_ADDR_DIV, 0, 0); `CHK(rd, {28'h0, div8 ? 4'h3 : 4'h0})
    rw(0, `SCKC_ADDR_CORE, 0, 0); `CHK(rd, {28'h0, cks2, 3'h0})
    rw(0, `SCKC_ADDR_PLL, 0, 0); `CHK(rd, 32'h10)
    rw(0, 12'h0ff, 0, 0); `CHK({err, rd}, 33'h100000000)
    rw(1, `SCKC_ADDR_TRIM, ~trim_in, 0); `CHK(trim_o, ~trim_in)
    // Select codes 0 to 9 through the protected sequence; reserved code 9 keeps the divider
    m_eff = div8 ? 3 : 0;
    for (int c = 0; c < 10; c++)
    begin
      rw(1, `SCKC_ADDR_DIV, 8'h80, 1); rw(1, `SCKC_ADDR_DIV, c[7:0], 0);
      if (c < 9) m_eff = c;
      rw(0, `SCKC_ADDR_DIV, 0, 0); `CHK(rd, c)
      per(p); per(p); `CHK(p, 1 << m_eff)
    end
    rw(1, `SCKC_ADDR_DIV, 8'h80, 1); rw(0, `SCKC_ADDR_DIV, 0, 0); `CHK(rd, 32'h89)
    rw(0, `SCKC_ADDR_DIV, 0, 0); `CHK(rd, 32'h9)
    rw(1, `SCKC_ADDR_DIV, 8'h80, 1); rw(1, `SCKC_ADDR_DIV, 8'h80, 1); rw(1, `SCKC_ADDR_DIV, 8'h2, 0);
    rw(0, `SCKC_ADDR_DIV, 0, 0); `CHK(rd, 32'h9)
    rw(1, `SCKC_ADDR_DIV, 8'hf1, 1); rw(1, `SCKC_ADDR_DIV, 8'h1, 0);
    rw(0, `SCKC_ADDR_DIV, 0, 0); `CHK(rd, 32'h9)
    for (int f = 2; f < 8; f++)
    begin
      rw(1, `SCKC_ADDR_PLL, 8'(f << 2 | 2), 0); rw(0, `SCKC_ADDR_PLL, 0, 0); `CHK(rd, f << 2 | 2)
      `CHK({pll_on, mult}, {1'b1, f < 7 ? 4'(f) : 4'h6})
    end
    lock <= 1; sysclk <= 1;
    rw(1, `SCKC_ADDR_PLL, 8'h18, 0); rw(0, `SCKC_ADDR_PLL, 0, 0); `CHK({psc_en, rd}, 33'h10000001b)
    sysclk <= 0;
    rw(1, `SCKC_ADDR_PLL, 8'h18, 0); rw(1, `SCKC_ADDR_CORE, 8'h04, 0); `CHK(rc1, 1'b1)
    rcrun <= 0;
    repeat (3) @(posedge clk);
    `CHK(rc1, 1'b0)
    test_done;
  end
endmodule // sckc_clock_ctrl_tb
